// >>> logic/iecps_pkg.sv
// Constants, types and address decode shared by the interrupt enable/pending slice
package iecps_pkg;

    localparam int unsigned IECPS_DATA_W = 32;
    localparam int unsigned IECPS_WORDS = 2;
    localparam int unsigned IECPS_LINES = 57;
    localparam int unsigned IECPS_NUM_W = 6;

    // Register byte addresses
    localparam logic [31:0] IECPS_ENABLE_SET_LO = 32'he000_e100;
    localparam logic [31:0] IECPS_ENABLE_SET_HI = 32'he000_e104;
    localparam logic [31:0] IECPS_ENABLE_CLEAR_LO = 32'he000_e180;
    localparam logic [31:0] IECPS_ENABLE_CLEAR_HI = 32'he000_e184;
    localparam logic [31:0] IECPS_PENDING_SET_LO = 32'he000_e200;
    localparam logic [31:0] IECPS_PENDING_SET_HI = 32'he000_e204;
    localparam logic [31:0] IECPS_PENDING_CLEAR_LO = 32'he000_e280;
    localparam logic [31:0] IECPS_PENDING_CLEAR_HI = 32'he000_e284;

    // Implemented bits per word; bit 20 and 31:25 of the upper word are absent
    localparam logic [31:0] IECPS_LO_VALID = 32'hffff_ffff;
    localparam logic [31:0] IECPS_HI_VALID = 32'h01ef_ffff;
    localparam logic [31:0] IECPS_ENABLE_RST = 32'h0000_0000;
    localparam logic [31:0] IECPS_PENDING_RST = 32'h0000_0000;

    // Lower word bit positions
    localparam int unsigned IECPS_LO_PORT0_PIN0 = 0;
    localparam int unsigned IECPS_LO_PORT1_PIN0 = 12;
    localparam int unsigned IECPS_LO_PORT2_PIN0 = 24;
    // Upper word bit positions
    localparam int unsigned IECPS_HI_PORT2_PIN8 = 0;
    localparam int unsigned IECPS_HI_PORT3_PIN0 = 4;
    localparam int unsigned IECPS_HI_TWO_WIRE = 8;
    localparam int unsigned IECPS_HI_SHORT_TIMER_ZERO = 9;
    localparam int unsigned IECPS_HI_SHORT_TIMER_ONE = 10;
    localparam int unsigned IECPS_HI_LONG_TIMER_ZERO = 11;
    localparam int unsigned IECPS_HI_LONG_TIMER_ONE = 12;
    localparam int unsigned IECPS_HI_SYNC_SERIAL_PORT = 13;
    localparam int unsigned IECPS_HI_UART = 14;
    localparam int unsigned IECPS_HI_USB_NORMAL = 15;
    localparam int unsigned IECPS_HI_USB_FAST = 16;
    localparam int unsigned IECPS_HI_ADC = 17;
    localparam int unsigned IECPS_HI_WATCHDOG = 18;
    localparam int unsigned IECPS_HI_BROWNOUT = 19;
    localparam int unsigned IECPS_HI_GPIO_PORT3 = 21;
    localparam int unsigned IECPS_HI_GPIO_PORT2 = 22;
    localparam int unsigned IECPS_HI_GPIO_PORT1 = 23;
    localparam int unsigned IECPS_HI_GPIO_PORT0 = 24;

    typedef enum {
        IECPS_REG_NONE,
        IECPS_REG_EN_SET,
        IECPS_REG_EN_CLR,
        IECPS_REG_PD_SET,
        IECPS_REG_PD_CLR
    } iecps_reg_e;

    typedef struct packed {
        logic [31:0] addr;
        logic write;
        logic [31:0] wdata;
    } iecps_apb_req_s;

    typedef struct packed {
        logic [31:0] en_set;
        logic [31:0] en_clr;
        logic [31:0] pd_set;
        logic [31:0] pd_clr;
    } iecps_wr_s;

    function automatic iecps_reg_e iecps_decode(input logic [31:0] addr);
        if (addr == IECPS_ENABLE_SET_LO || addr == IECPS_ENABLE_SET_HI) begin
            return IECPS_REG_EN_SET;
        end else if (addr == IECPS_ENABLE_CLEAR_LO || addr == IECPS_ENABLE_CLEAR_HI) begin
            return IECPS_REG_EN_CLR;
        end else if (addr == IECPS_PENDING_SET_LO || addr == IECPS_PENDING_SET_HI) begin
            return IECPS_REG_PD_SET;
        end else if (addr == IECPS_PENDING_CLEAR_LO || addr == IECPS_PENDING_CLEAR_HI) begin
            return IECPS_REG_PD_CLR;
        end else begin
            return IECPS_REG_NONE;
        end
    endfunction : iecps_decode

    // Word select: bit 2 of the byte address picks upper or lower word
    function automatic logic iecps_is_hi(input logic [31:0] addr);
        return addr[2];
    endfunction : iecps_is_hi

endpackage : iecps_pkg

// >>> logic/iecps_flag_word.sv
// One word of set/clear flags with a fixed implemented-bit mask
`timescale 1ns/1ps
`default_nettype none
module iecps_flag_word
    import iecps_pkg::*;
#(
    parameter int unsigned W = 32,
    parameter logic [W-1:0] VALID = '1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic [W-1:0] set_i,
    input wire logic [W-1:0] clr_i,
    output logic [W-1:0] q_o
);

    logic [W-1:0] q;
    logic [W-1:0] next_q;

    // Set wins over a clear in the same cycle; zero bits change nothing
    always_comb begin
        next_q = ((q & ~clr_i) | set_i) & VALID;
    end

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            q <= RST_VAL;
        end else begin
            q <= next_q;
        end
    end

    assign q_o = q;

endmodule : iecps_flag_word
`default_nettype wire

// >>> logic/iecps_apb_front.sv
// APB slave handshake: one wait state, write strobe at completion
`timescale 1ns/1ps
`default_nettype none
module iecps_apb_front
    import iecps_pkg::*;
(
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire iecps_apb_req_s req_i,
    input wire logic [31:0] rdata_i,
    input wire logic hit_i,
    output logic pready_o,
    output logic [31:0] prdata_o,
    output logic pslverr_o,
    output logic wr_fire_o
);

    typedef enum {IECPS_ST_IDLE, IECPS_ST_RESP} iecps_state_e;

    iecps_state_e state;
    iecps_state_e next_state;
    logic next_pready;
    logic [31:0] next_prdata;
    logic next_pslverr;

    always_comb begin
        next_state = state;
        next_pready = 1'b0;
        next_prdata = 32'h0000_0000;
        next_pslverr = 1'b0;
        case (state)
            IECPS_ST_IDLE: begin
                if (psel_i && penable_i) begin
                    next_state = IECPS_ST_RESP;
                    next_pready = 1'b1;
                    next_prdata = req_i.write ? 32'h0000_0000 : rdata_i;
                    next_pslverr = ~hit_i;
                end
            end
            IECPS_ST_RESP: begin
                next_state = IECPS_ST_IDLE;
            end
            default: begin
                next_state = IECPS_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            state <= IECPS_ST_IDLE;
            pready_o <= 1'b0;
            prdata_o <= 32'h0000_0000;
            pslverr_o <= 1'b0;
        end else begin
            state <= next_state;
            pready_o <= next_pready;
            prdata_o <= next_prdata;
            pslverr_o <= next_pslverr;
        end
    end

    // Effect lands only at the completing edge; unmapped writes are dropped
    assign wr_fire_o = psel_i && penable_i && pready_o && req_i.write && hit_i;

endmodule : iecps_apb_front
`default_nettype wire

// >>> logic/iecps_core.sv
// Interrupt enable and pending state with its APB register slice
//
// Implementation choice: the APB slave port.
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - Lower clear-enable word disables lines 0 to 31
// - Upper clear-enable word disables lines from 32
// - Written one clears only its own enable
// - Written zeros change no enable or pending
// - Clear-enable read shows current enable state
// - Lower set-pending word pends lines 0 to 31
// - Set-pending write works regardless of source
// - Set-pending read shows current pending flags
// - Low bits: port 0 and port 1 wake pins
// - Bits 24 to 31: port 2 pins 0-7
// - Upper bits 0-7: port 2 high, port 3
// - Upper 8-12: two-wire, short and long timers
// - Upper 13-19: serial, UART, USB, ADC, watchdog, brownout
// - Upper 21-24: GPIO ports 3 down to 0
// - Reserved upper bits read back as zero
// - Clear-enable shares state with set-enable
// - Set-pending shares flags with clear-pending
module iecps_core
    import iecps_pkg::*;
#(
    parameter int unsigned LINES = IECPS_LINES
) (
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [31:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire logic [LINES-1:0] irq_src_i,
    input wire logic [LINES-1:0] irq_ack_i,
    output logic [LINES-1:0] irq_enable_o,
    output logic [LINES-1:0] irq_pending_o,
    output logic irq_req_o,
    output logic [IECPS_NUM_W-1:0] irq_num_o
);

    localparam int unsigned VEC_W = IECPS_WORDS * IECPS_DATA_W;
    localparam logic [VEC_W-1:0] VALID = {IECPS_HI_VALID, IECPS_LO_VALID};

    iecps_apb_req_s req;
    iecps_reg_e reg_sel;
    iecps_wr_s wr [IECPS_WORDS];
    logic wr_fire;
    logic hit;
    logic hi_sel;
    logic [31:0] rd_value;
    logic [VEC_W-1:0] enable_vec;
    logic [VEC_W-1:0] pending_vec;
    logic [VEC_W-1:0] src_vec;
    logic [VEC_W-1:0] ack_vec;
    logic [VEC_W-1:0] active_vec;

    logic [LINES-1:0] next_enable;
    logic [LINES-1:0] next_pending;
    logic next_req;
    logic [IECPS_NUM_W-1:0] next_num;

    assign req.addr = paddr_i;
    assign req.write = pwrite_i;
    assign req.wdata = pwdata_i;
    assign reg_sel = iecps_decode(paddr_i);
    assign hi_sel = iecps_is_hi(paddr_i);
    assign hit = (reg_sel != IECPS_REG_NONE);

    // Sources and acks beyond LINES are tied low; reserved positions never hold state
    assign src_vec = {{(VEC_W - LINES){1'b0}}, irq_src_i};
    assign ack_vec = {{(VEC_W - LINES){1'b0}}, irq_ack_i};

    // Read-back word: both enable registers show enable, both pending show pending
    function automatic logic [31:0] read_word(
        input iecps_reg_e sel,
        input logic hi,
        input logic [VEC_W-1:0] en,
        input logic [VEC_W-1:0] pd
    );
        logic [31:0] lo_en;
        logic [31:0] hi_en;
        logic [31:0] lo_pd;
        logic [31:0] hi_pd;
        lo_en = en[31:0];
        hi_en = en[63:32];
        lo_pd = pd[31:0];
        hi_pd = pd[63:32];
        if (sel == IECPS_REG_EN_SET || sel == IECPS_REG_EN_CLR) begin
            return hi ? hi_en : lo_en;
        end else if (sel == IECPS_REG_PD_SET || sel == IECPS_REG_PD_CLR) begin
            return hi ? hi_pd : lo_pd;
        end else begin
            return 32'h0000_0000;
        end
    endfunction : read_word

    // Reserved upper bits simply read zero since the VALID mask and reset hold their flops at zero
    assign rd_value = read_word(reg_sel, hi_sel, enable_vec, pending_vec);

    iecps_apb_front u_front (
        .mclk_i(mclk_i),
        .rst_i(rst_i),
        .psel_i(psel_i),
        .penable_i(penable_i),
        .req_i(req),
        .rdata_i(rd_value),
        .hit_i(hit),
        .pready_o(pready_o),
        .prdata_o(prdata_o),
        .pslverr_o(pslverr_o),
        .wr_fire_o(wr_fire)
    );

    genvar w;
    generate
        for (w = 0; w < IECPS_WORDS; w++) begin : g_word
            localparam logic [31:0] WVALID = VALID[w*32 +: 32];
            localparam logic W_HI = (w != 0);
            logic word_hit;
            logic [31:0] data;
            logic [31:0] en_q;
            logic [31:0] pd_q;

            assign word_hit = wr_fire && (hi_sel == W_HI);
            // Stray ones on reserved bits are masked, so they cannot create state
            assign data = req.wdata & WVALID;

            always_comb begin
                wr[w].en_set = 32'h0000_0000;
                wr[w].en_clr = 32'h0000_0000;
                wr[w].pd_set = 32'h0000_0000;
                wr[w].pd_clr = 32'h0000_0000;
                if (word_hit) begin
                    if (reg_sel == IECPS_REG_EN_SET) begin
                        wr[w].en_set = data;
                    end else if (reg_sel == IECPS_REG_EN_CLR) begin
                        wr[w].en_clr = data;
                    end else if (reg_sel == IECPS_REG_PD_SET) begin
                        wr[w].pd_set = data;
                    end else if (reg_sel == IECPS_REG_PD_CLR) begin
                        wr[w].pd_clr = data;
                    end
                end
            end

            iecps_flag_word #(
                .W(32),
                .VALID(WVALID),
                .RST_VAL(IECPS_ENABLE_RST)
            ) u_enable (
                .mclk_i(mclk_i),
                .rst_i(rst_i),
                .set_i(wr[w].en_set),
                .clr_i(wr[w].en_clr),
                .q_o(en_q)
            );

            // Source level and software both set; ack or software clear drop it,
            // but any set in the same cycle wins
            iecps_flag_word #(
                .W(32),
                .VALID(WVALID),
                .RST_VAL(IECPS_PENDING_RST)
            ) u_pending (
                .mclk_i(mclk_i),
                .rst_i(rst_i),
                .set_i(wr[w].pd_set | src_vec[w*32 +: 32]),
                .clr_i(wr[w].pd_clr | ack_vec[w*32 +: 32]),
                .q_o(pd_q)
            );

            assign enable_vec[w*32 +: 32] = en_q;
            assign pending_vec[w*32 +: 32] = pd_q;
        end
    endgenerate

    // Bit order maps straight to sources: lower word wake pins of ports 0..2,
    // upper word remaining wake pins then peripherals; line n is bit n
    assign active_vec = enable_vec & pending_vec;

    // Lowest numbered active line wins the request
    function automatic logic [IECPS_NUM_W-1:0] first_line(input logic [VEC_W-1:0] v);
        logic [IECPS_NUM_W-1:0] n;
        n = '0;
        for (int i = VEC_W - 1; i >= 0; i--) begin
            if (v[i]) begin
                n = IECPS_NUM_W'(i);
            end
        end
        return n;
    endfunction : first_line

    always_comb begin
        next_enable = enable_vec[LINES-1:0];
        next_pending = pending_vec[LINES-1:0];
        next_req = |active_vec;
        next_num = first_line(active_vec);
    end

    // Outputs lag internal state by one cycle to come straight from flops
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            irq_enable_o <= '0;
            irq_pending_o <= '0;
            irq_req_o <= 1'b0;
            irq_num_o <= '0;
        end else begin
            irq_enable_o <= next_enable;
            irq_pending_o <= next_pending;
            irq_req_o <= next_req;
            irq_num_o <= next_num;
        end
    end

endmodule : iecps_core
`default_nettype wire

// >>> tb/iecps_core_properties.sv
// Concurrent checks on the ports of the enable/pending register slice
`timescale 1ns/1ps
`default_nettype none
module iecps_core_properties
    import iecps_pkg::*;
#(
    parameter int unsigned LINES = IECPS_LINES
) (
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [31:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [31:0] prdata_o,
    input wire logic pready_o,
    input wire logic pslverr_o,
    input wire logic [LINES-1:0] irq_src_i,
    input wire logic [LINES-1:0] irq_ack_i,
    input wire logic [LINES-1:0] irq_enable_o,
    input wire logic [LINES-1:0] irq_pending_o,
    input wire logic irq_req_o,
    input wire logic [IECPS_NUM_W-1:0] irq_num_o
);
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (rst_i);
    logic done;
    logic mapped;
    assign done = psel_i && penable_i && pready_o;
    assign mapped = paddr_i[31:12] == 20'he000e && paddr_i[11:0] inside
        {12'h100, 12'h104, 12'h180, 12'h184, 12'h200, 12'h204, 12'h280, 12'h284};
    sequence s_wait;
        psel_i && penable_i && !pready_o;
    endsequence
    sequence s_wr(logic [31:0] a);
        done && pwrite_i && paddr_i == a;
    endsequence
    sequence s_rd(logic [31:0] a);
        done && !pwrite_i && paddr_i == a;
    endsequence
    a_ready_after_wait: assert property (s_wait |=> pready_o) else $error("no ready");
    a_ready_one_cycle: assert property (pready_o |=> !pready_o) else $error("ready held");
    a_error_on_unmapped: assert property (pready_o |-> pslverr_o == !mapped)
        else $error("error flag wrong");
    a_clear_lo_word: assert property (s_wr(IECPS_ENABLE_CLEAR_LO) |-> ##2
        irq_enable_o[31:0] == ($past(irq_enable_o[31:0]) & ~$past(pwdata_i, 2)))
        else $error("low clear wrong");
    a_clear_hi_word: assert property (s_wr(IECPS_ENABLE_CLEAR_HI) |-> ##2
        irq_enable_o[LINES-1:32] ==
        ($past(irq_enable_o[LINES-1:32]) & ~$past(pwdata_i[LINES-33:0], 2)))
        else $error("high clear wrong");
    a_set_shared_state: assert property (s_wr(IECPS_ENABLE_SET_LO) |-> ##2
        irq_enable_o[31:0] == ($past(irq_enable_o[31:0]) | $past(pwdata_i, 2)))
        else $error("set enable wrong");
    a_pend_set_wins: assert property (s_wr(IECPS_PENDING_SET_LO) |-> ##2
        (irq_pending_o[31:0] & $past(pwdata_i, 2)) == $past(pwdata_i, 2))
        else $error("pending set lost");
    a_read_clear_lo: assert property (s_rd(IECPS_ENABLE_CLEAR_LO) |->
        prdata_o == irq_enable_o[31:0]) else $error("low enable read wrong");
    a_read_clear_hi: assert property (s_rd(IECPS_ENABLE_CLEAR_HI) |->
        (prdata_o & IECPS_HI_VALID) == (32'(irq_enable_o[LINES-1:32]) & IECPS_HI_VALID))
        else $error("high enable read wrong");
    a_read_pend_lo: assert property (s_rd(IECPS_PENDING_SET_LO) |->
        prdata_o == irq_pending_o[31:0]) else $error("pending read wrong");
    a_reset_all_clear: assert property (disable iff (1'b0) $fell(rst_i) |->
        irq_enable_o == '0 && irq_pending_o == '0 && !irq_req_o)
        else $error("state after reset");
endmodule : iecps_core_properties
bind iecps_core iecps_core_properties #(.LINES(LINES)) u_props (.mclk_i(mclk_i),
    .rst_i(rst_i), .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
    .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
    .pslverr_o(pslverr_o), .irq_src_i(irq_src_i), .irq_ack_i(irq_ack_i),
    .irq_enable_o(irq_enable_o), .irq_pending_o(irq_pending_o), .irq_req_o(irq_req_o),
    .irq_num_o(irq_num_o));
`default_nettype wire

// >>> tb/iecps_core_tb.sv
// Random and corner stimulus for the enable/pending register slice
`timescale 1ns/1ps
`default_nettype none
module iecps_core_tb
    import iecps_pkg::*;
;
    logic mclk_i = 1'b0;
    logic rst_i = 1'b1;
    logic psel_i = 1'b0;
    logic penable_i = 1'b0;
    logic pwrite_i = 1'b0;
    logic [31:0] paddr_i = 32'h0;
    logic [31:0] pwdata_i = 32'h0;
    logic [56:0] irq_src_i = '0;
    logic [56:0] irq_ack_i = '0;
    logic [31:0] prdata_o;
    logic pready_o;
    logic pslverr_o;
    logic irq_req_o;
    logic [56:0] irq_enable_o;
    logic [56:0] irq_pending_o;
    logic [5:0] irq_num_o;
    logic [56:0] en = '0;
    logic [56:0] pd = '0;
    logic [31:0] rd;
    logic er;
    int err_count = 0;
    int checked = 0;
    int seed = 32;
    // Even index low word, odd high word, last one unmapped
    logic [31:0] adr [9] = '{IECPS_ENABLE_SET_LO, IECPS_ENABLE_SET_HI, IECPS_ENABLE_CLEAR_LO,
        IECPS_ENABLE_CLEAR_HI, IECPS_PENDING_SET_LO, IECPS_PENDING_SET_HI,
        IECPS_PENDING_CLEAR_LO, IECPS_PENDING_CLEAR_HI, 32'he000_e188};
    int ci [8] = '{0, 1, 3, 2, 2, 4, 6, 8};
    logic [31:0] cd [8] = '{32'hffff_ffff, 32'hffff_ffff, 32'h0108_0000, 32'h0,
        32'h0100_0000, 32'h8000_0001, 32'h8000_0000, 32'hffff_ffff};

    always #2.5 mclk_i = ~mclk_i;

    iecps_core #(.LINES(57)) dut (.mclk_i(mclk_i), .rst_i(rst_i), .psel_i(psel_i),
        .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
        .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
        .irq_src_i(irq_src_i), .irq_ack_i(irq_ack_i), .irq_enable_o(irq_enable_o),
        .irq_pending_o(irq_pending_o), .irq_req_o(irq_req_o), .irq_num_o(irq_num_o));

    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : complete_run

    task automatic check(input string what, input logic [63:0] exp, input logic [63:0] got);
        checked++;
        if (exp !== got) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    // Called right after an edge; returns at the edge that saw pready
    task automatic apb(input logic [31:0] a, input logic w, input logic [31:0] d,
            output logic [31:0] r, output logic e);
        int n;
        psel_i <= 1'b1;
        penable_i <= 1'b0;
        paddr_i <= a;
        pwrite_i <= w;
        pwdata_i <= d;
        @(posedge mclk_i);
        penable_i <= 1'b1;
        n = 0;
        do begin
            @(posedge mclk_i);
            n++;
        end while (pready_o !== 1'b1 && n < 20);
        if (n >= 20) begin
            err_count++;
            complete_run();
        end
        r = prdata_o;
        e = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
    endtask : apb

    function automatic logic [5:0] lowest(input logic [56:0] v);
        lowest = 6'h0;
        for (int i = 56; i >= 0; i--) if (v[i]) lowest = i[5:0];
    endfunction : lowest

    function automatic logic [31:0] exp_read(input int i);
        logic [63:0] v;
        v = (i < 4) ? 64'(en) : 64'(pd);
        if (i == 8) return 32'h0;
        return (i % 2) ? v[63:32] : v[31:0];
    endfunction : exp_read

    task automatic op(input int i, input logic [31:0] d);
        logic [31:0] x;
        logic [56:0] m;
        // Reserved high bits are never written with ones
        x = (i % 2) ? (d & IECPS_HI_VALID) : d;
        m = (i % 2) ? {x[24:0], 32'h0} : {25'h0, x};
        case (i / 2)
            0: en = en | m;
            1: en = en & ~m;
            2: pd = pd | m;
            3: pd = pd & ~m;
            default: ;
        endcase
        apb(adr[i], 1'b1, x, rd, er);
        check("write error", 64'(i == 8), 64'(er));
        @(posedge mclk_i);
        #1;
        check("enable", 64'(en), 64'(irq_enable_o));
        check("pending", 64'(pd), 64'(irq_pending_o));
        check("request", 64'(|(en & pd)), 64'(irq_req_o));
        check("number", 64'(lowest(en & pd)), 64'(irq_num_o));
        @(posedge mclk_i);
        apb(adr[i], 1'b0, 32'h0, rd, er);
        check("read", 64'(exp_read(i)), 64'(rd & ((i % 2) ? IECPS_HI_VALID : 32'hffff_ffff)));
        // Idle edge so the next request never reassigns psel in the release step
        @(posedge mclk_i);
    endtask : op

    initial begin
        repeat (4) @(posedge mclk_i);
        rst_i <= 1'b0;
        @(posedge mclk_i);
        for (int i = 0; i < 8; i++) op(i, 32'h0);
        for (int i = 0; i < 8; i++) op(ci[i], cd[i]);
        irq_ack_i <= '1;
        apb(adr[4], 1'b1, 32'h8000_0001, rd, er);
        @(posedge mclk_i);
        #1;
        check("set over clear", 64'h8000_0001, 64'(irq_pending_o));
        @(posedge mclk_i);
        irq_ack_i <= '0;
        pd = '0;
        irq_src_i <= 57'h1 << 45;
        @(posedge mclk_i);
        irq_src_i <= '0;
        pd[45] = 1'b1;
        op(5, 32'h0);
        for (int k = 0; k < 60; k++) op($unsigned($random(seed)) % 9, $random(seed));
        complete_run();
    end
endmodule : iecps_core_tb
`default_nettype wire
